// *** design/irda_pulse_shaper.sv ***
`timescale 1ns/1ps
module irda_pulse_shaper
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_enable,
  input  wire logic i_quarter,
  input  wire logic i_sample_tick,
  input  wire logic i_bit_start,
  input  wire logic i_tx_bit,
  output logic      o_tx
);

  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic       zero_q;
  logic       zero_d;
  logic       tx_q;
  logic       tx_d;
  logic [3:0] width;

  // a zero bit becomes a short high pulse at the start of the bit cell
  always_comb
  begin
    width = i_quarter ? uart_xfc_pkg::IRDA_WIDTH_QUARTER : uart_xfc_pkg::IRDA_WIDTH_316;
    phase_d = phase_q;
    zero_d = zero_q;
    if (i_bit_start)
    begin
      phase_d = 4'h0;
      zero_d = ~i_tx_bit;
    end
    else if (i_sample_tick && phase_q != 4'hf)
    begin
      phase_d = phase_q + 4'h1;
    end
    if (i_enable)
      tx_d = zero_d && (phase_d < width);
    else
      tx_d = i_tx_bit;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      phase_q <= 4'hf;
      zero_q <= 1'b0;
      tx_q <= 1'b1;
    end
    else
    begin
      phase_q <= phase_d;
      zero_q <= zero_d;
      tx_q <= tx_d;
    end
  end

  assign o_tx = tx_q;

endmodule

// *** design/uart_extra_feature_ctrl.sv ***
`timescale 1ns/1ps
// What this block does
// - software reset from the gpio control area clears every channel's state here.
// - extra feature control at 0x0f only while special page bit clear; resets zero.
// - bit 7 picks infrared pulse: clear 3/16 bit, set 1/4 bit.
// - bit 5 inverts direction output; clear means low while transmitting.
// - polarity matters only when automatic direction control is on.
// - bit 4 lets the transmitter drive request-to-send; otherwise left alone.
// - bit 2 lets the current character finish, then blocks further transmission.
// - bit 1 disables reception; clearing it re-enables reception.
// - bit 0 selects nine-bit multidrop characters instead of normal eight-bit.
// - unlock key register reachable only with line control 0xbf; resets zero.
// - only key 0x5a held in the key register opens the special function register.
// - flow status readable only with line control 0xbf and page bit set.
// - status bit 1 sets once we sent xoff or dropped request-to-send.
// - status bit 0 is high while the remote end holds our transmitter off.
// - page bit set opens second page registers and hides extra feature control.
// - special function register reachable with line control 0xbf and key 0x5a.
module uart_extra_feature_ctrl
(
  input  wire logic                       i_clk,
  input  wire logic                       i_reset,
  input  wire logic                       i_soft_reset,
  input  wire logic [3:0]                 i_reg_addr,
  input  wire logic                       i_reg_wr,
  input  wire logic                       i_reg_rd,
  input  wire logic [7:0]                 i_reg_wdata,
  input  wire logic [7:0]                 i_line_control,
  input  wire uart_xfc_pkg::flow_events_t i_flow,
  input  wire logic                       i_tx_fifo_nonempty,
  input  wire logic                       i_tx_shifting,
  input  wire logic                       i_rts_n_manual,
  input  wire logic                       i_tx_bit,
  input  wire logic                       i_bit_start,
  input  wire logic                       i_sample_tick,
  input  wire logic                       i_irda_enable,
  output logic [7:0]                      o_reg_rdata,
  output logic                            o_reg_hit,
  output logic                            o_special_page,
  output logic                            o_tx_load_allow,
  output logic                            o_rx_enable,
  output logic                            o_nine_bit_mode,
  output logic                            o_rts_n,
  output logic                            o_tx_line
);

  logic                      rst;
  logic [7:0]                efc_q;
  logic [7:0]                efc_d;
  logic [7:0]                key_q;
  logic [7:0]                key_d;
  logic [7:0]                sfr_q;
  logic [7:0]                sfr_d;
  logic [7:0]                rdata_q;
  logic [7:0]                rdata_d;
  logic                      hit_q;
  logic                      hit_d;
  uart_xfc_pkg::flow_state_t flow_q;
  uart_xfc_pkg::flow_state_t flow_d;
  logic                      halt_sent_q;
  logic                      halt_sent_d;
  logic                      term_q;
  logic                      term_d;
  logic                      rts_n_q;
  logic                      rts_n_d;
  logic                      tx_allow_q;
  logic                      tx_allow_d;
  logic                      rx_en_q;
  logic                      rx_en_d;
  logic                      lcr_special;
  logic                      page;
  logic                      sel_efc;
  logic                      sel_key;
  logic                      sel_sfr;
  logic                      sel_asr;
  logic                      tx_active;

  // the gpio software reset is shared by all channels, so it clears everything
  assign rst = i_reset || i_soft_reset;

  // address decode: each register opens only in its documented access window
  always_comb
  begin
    lcr_special = (i_line_control == uart_xfc_pkg::LCR_SPECIAL_VALUE);
    page = sfr_q[uart_xfc_pkg::SFR_SPECIAL_PAGE];
    sel_efc = 1'b0;
    sel_key = 1'b0;
    sel_sfr = 1'b0;
    sel_asr = 1'b0;
    if (i_reg_addr == uart_xfc_pkg::ADDR_EXTRA_FEAT)
      sel_efc = !page;
    else if (i_reg_addr == uart_xfc_pkg::ADDR_UNLOCK_KEY)
      sel_key = lcr_special;
    else if (i_reg_addr == uart_xfc_pkg::ADDR_SPECIAL_FUNC)
      sel_sfr = lcr_special && (key_q == uart_xfc_pkg::UNLOCK_KEY_VALUE);
    else if (i_reg_addr == uart_xfc_pkg::ADDR_FLOW_STATUS)
      sel_asr = lcr_special && page;
  end

  // register writes; reserved extra feature control bits are masked to zero
  always_comb
  begin
    efc_d = efc_q;
    key_d = key_q;
    sfr_d = sfr_q;
    if (i_reg_wr && sel_efc)
      efc_d = i_reg_wdata & uart_xfc_pkg::EFC_WRITE_MASK;
    if (i_reg_wr && sel_key)
      key_d = i_reg_wdata;
    if (i_reg_wr && sel_sfr)
      sfr_d = i_reg_wdata;
    // the enables get their own flops so the outputs carry no inverter
    tx_allow_d = !efc_d[uart_xfc_pkg::EFC_TX_DISABLE];
    rx_en_d = !efc_d[uart_xfc_pkg::EFC_RX_DISABLE];
  end

  // read data is registered, one cycle after the strobe; flow status has no write path
  always_comb
  begin
    rdata_d = rdata_q;
    hit_d = 1'b0;
    if (i_reg_rd)
    begin
      hit_d = sel_efc || sel_key || sel_sfr || sel_asr;
      rdata_d = 8'h00;
      if (sel_efc)
        rdata_d = efc_q;
      else if (sel_key)
        rdata_d = key_q;
      else if (sel_sfr)
        rdata_d = sfr_q;
      else if (sel_asr)
        rdata_d = {2'b00, flow_q, 2'b00, halt_sent_q, term_q};
    end
  end

  // software flow-control state as seen by the status register
  always_comb
  begin
    flow_d = flow_q;
    case (flow_q)
      uart_xfc_pkg::FLOW_IDLE:
        if (i_flow.xoff_rcvd)
          flow_d = uart_xfc_pkg::FLOW_XOFF_RCVD;
      uart_xfc_pkg::FLOW_XOFF_RCVD:
        if (i_flow.xon_rcvd)
          flow_d = uart_xfc_pkg::FLOW_XON_RCVD;
        else if (i_flow.remote_halt)
          flow_d = uart_xfc_pkg::FLOW_TX_OFF;
      uart_xfc_pkg::FLOW_TX_OFF:
        if (i_flow.xon_rcvd)
          flow_d = uart_xfc_pkg::FLOW_XON_RCVD;
      uart_xfc_pkg::FLOW_XON_RCVD:
        if (i_flow.xoff_rcvd)
          flow_d = uart_xfc_pkg::FLOW_XOFF_RCVD;
        else if (!i_flow.remote_halt)
          flow_d = uart_xfc_pkg::FLOW_IDLE;
      default:
        flow_d = uart_xfc_pkg::FLOW_IDLE;
    endcase
    // set beats clear so a halt in the resume cycle is not lost
    halt_sent_d = i_flow.sent_halt || (halt_sent_q && !i_flow.remote_resumed);
    term_d = i_flow.remote_halt;
  end

  // direction output: active until the shifter has sent its last stop bit
  always_comb
  begin
    tx_active = i_tx_shifting || (i_tx_fifo_nonempty && !efc_q[uart_xfc_pkg::EFC_TX_DISABLE]);
    if (efc_q[uart_xfc_pkg::EFC_RS485_AUTO])
      rts_n_d = tx_active ~^ efc_q[uart_xfc_pkg::EFC_RS485_INVERT];
    else
      rts_n_d = i_rts_n_manual;
  end

  always_ff @(posedge i_clk)
  begin
    if (rst)
    begin
      efc_q <= uart_xfc_pkg::EXTRA_FEAT_RESET;
      key_q <= uart_xfc_pkg::UNLOCK_KEY_RESET;
      sfr_q <= uart_xfc_pkg::SPECIAL_FUNC_RESET;
      rdata_q <= 8'h00;
      hit_q <= 1'b0;
      flow_q <= uart_xfc_pkg::FLOW_IDLE;
      halt_sent_q <= 1'b0;
      term_q <= 1'b0;
      rts_n_q <= 1'b1;
      tx_allow_q <= 1'b1;
      rx_en_q <= 1'b1;
    end
    else
    begin
      efc_q <= efc_d;
      key_q <= key_d;
      sfr_q <= sfr_d;
      rdata_q <= rdata_d;
      hit_q <= hit_d;
      flow_q <= flow_d;
      halt_sent_q <= halt_sent_d;
      term_q <= term_d;
      rts_n_q <= rts_n_d;
      tx_allow_q <= tx_allow_d;
      rx_en_q <= rx_en_d;
    end
  end

  // infrared encoder sits on the serial output
  irda_pulse_shaper u_irda
  (
    .i_clk         (i_clk),
    .i_rst         (rst),
    .i_enable      (i_irda_enable),
    .i_quarter     (efc_q[uart_xfc_pkg::EFC_IRDA_QUARTER]),
    .i_sample_tick (i_sample_tick),
    .i_bit_start   (i_bit_start),
    .i_tx_bit      (i_tx_bit),
    .o_tx          (o_tx_line)
  );

  // mode controls come straight from flops: register bits, the two enables from their own flops
  assign o_reg_rdata = rdata_q;
  assign o_reg_hit = hit_q;
  assign o_special_page = sfr_q[uart_xfc_pkg::SFR_SPECIAL_PAGE];
  assign o_tx_load_allow = tx_allow_q;
  assign o_rx_enable = rx_en_q;
  assign o_nine_bit_mode = efc_q[uart_xfc_pkg::EFC_NINE_BIT];
  assign o_rts_n = rts_n_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);

  sequence s_key_written;
    i_reg_wr && sel_key && i_reg_wdata == uart_xfc_pkg::UNLOCK_KEY_VALUE;
  endsequence

  sequence s_sfr_read;
    i_reg_rd && i_reg_addr == 4'h7 && lcr_special;
  endsequence

  // soft reset is part of the default disable, so this one stops only on the pin reset
  chk_soft_reset_clear: assert property (
    disable iff (i_reset) i_soft_reset |=> efc_q == 8'h00 && key_q == 8'h00 && sfr_q == 8'h00)
    else $error("soft reset did not clear registers");
  chk_efc_page_block: assert property (
    i_reg_wr && page && i_reg_addr == 4'hf |=> $stable(efc_q))
    else $error("extra feature control written while page set");
  chk_key_lcr_gate: assert property (
    i_reg_wr && i_reg_addr == 4'hd && !lcr_special |=> $stable(key_q))
    else $error("key written without special line control");
  chk_sfr_key_gate: assert property (
    i_reg_wr && i_reg_addr == 4'h7 && key_q != 8'h5a |=> $stable(sfr_q))
    else $error("special function written without key");
  chk_key_opens_sfr: assert property (
    s_key_written ##2 s_sfr_read |=> hit_q)
    else $error("key did not open special function register");
  chk_asr_gate: assert property (
    i_reg_rd && i_reg_addr == 4'h2 && !(lcr_special && page) |=> !hit_q)
    else $error("flow status answered outside its window");
  chk_rts_polarity: assert property (
    efc_q[4] && i_tx_shifting |=> o_rts_n == $past(efc_q[5]))
    else $error("direction level wrong while transmitting");
  chk_rts_manual: assert property (
    !efc_q[4] |=> o_rts_n == $past(i_rts_n_manual))
    else $error("direction control drove pin while off");
  chk_halt_set: assert property (
    i_flow.sent_halt |=> halt_sent_q)
    else $error("halt sent flag not set");
  chk_halt_sticky: assert property (
    halt_sent_q && !i_flow.remote_resumed |=> halt_sent_q)
    else $error("halt sent flag lost");
  chk_reserved_zero: assert property (
    i_reg_rd && sel_efc |=> (o_reg_rdata & 8'h48) == 8'h00)
    else $error("reserved bits read nonzero");

endmodule

// *** design/uart_xfc_pkg.sv ***
package uart_xfc_pkg;

  // register offsets on the internal register port
  localparam logic [3:0] ADDR_FLOW_STATUS = 4'h2;
  localparam logic [3:0] ADDR_SPECIAL_FUNC = 4'h7;
  localparam logic [3:0] ADDR_UNLOCK_KEY = 4'hd;
  localparam logic [3:0] ADDR_EXTRA_FEAT = 4'hf;

  // access keys
  localparam logic [7:0] LCR_SPECIAL_VALUE = 8'hbf;
  localparam logic [7:0] UNLOCK_KEY_VALUE = 8'h5a;

  // reset values
  localparam logic [7:0] EXTRA_FEAT_RESET = 8'h00;
  localparam logic [7:0] UNLOCK_KEY_RESET = 8'h00;
  localparam logic [7:0] SPECIAL_FUNC_RESET = 8'h00;

  // extra feature control fields
  localparam int EFC_IRDA_QUARTER = 7;
  localparam int EFC_RS485_INVERT = 5;
  localparam int EFC_RS485_AUTO = 4;
  localparam int EFC_TX_DISABLE = 2;
  localparam int EFC_RX_DISABLE = 1;
  localparam int EFC_NINE_BIT = 0;
  localparam logic [7:0] EFC_WRITE_MASK = 8'hb7;

  // special function field that opens the second register page
  localparam int SFR_SPECIAL_PAGE = 2;

  // infrared pulse widths in 16x sample ticks
  localparam logic [3:0] IRDA_WIDTH_316 = 4'h3;
  localparam logic [3:0] IRDA_WIDTH_QUARTER = 4'h4;

  typedef enum logic [1:0] {
    FLOW_IDLE,
    FLOW_XOFF_RCVD,
    FLOW_TX_OFF,
    FLOW_XON_RCVD
  } flow_state_t;

  // events from the software flow-control logic of the uart core
  typedef struct packed {
    logic xoff_rcvd;
    logic xon_rcvd;
    logic remote_halt;
    logic sent_halt;
    logic remote_resumed;
  } flow_events_t;

endpackage

// *** dv/remote_uart_model.sv ***
`timescale 1ns/1ps
// far-side uart: turns bench requests into the flow events the core reports
module remote_uart_model
(
  input  wire logic                  i_clk,
  input  wire logic [4:0]            i_req,
  output uart_xfc_pkg::flow_events_t o_flow
);
  logic [4:0] req_q;

  // requests are edge-detected so each event is one cycle long, halt stays a level
  always_ff @(posedge i_clk)
  begin
    req_q <= i_req;
  end

  // xoff, xon and our own halt or resume notices
  assign o_flow = {i_req[4:3] & ~req_q[4:3], i_req[2], i_req[1:0] & ~req_q[1:0]};
endmodule

// *** dv/uart_extra_feature_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module uart_extra_feature_ctrl_tb_top;
  logic                       i_clk, i_reset, i_soft_reset, i_reg_wr, i_reg_rd;
  logic [3:0]                 i_reg_addr;
  logic [7:0]                 i_reg_wdata, i_line_control, o_reg_rdata;
  logic [4:0]                 flow_req;
  uart_xfc_pkg::flow_events_t i_flow;
  logic                       i_fifo, i_shift, i_rts_man, i_tx_bit, i_bit_start, i_tick, i_irda;
  logic                       o_reg_hit, o_page, o_load, o_rx_en, o_nine, o_rts_n, o_tx_line;
  logic                       rd_sh;
  logic [8:0]                 exp_q[$];
  logic [16:0]                lfsr;
  int                         mismatches, n_tests, cnt;

  uart_extra_feature_ctrl u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_soft_reset(i_soft_reset),
    .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .i_line_control(i_line_control), .i_flow(i_flow),
    .i_tx_fifo_nonempty(i_fifo), .i_tx_shifting(i_shift), .i_rts_n_manual(i_rts_man),
    .i_tx_bit(i_tx_bit), .i_bit_start(i_bit_start), .i_sample_tick(i_tick),
    .i_irda_enable(i_irda), .o_reg_rdata(o_reg_rdata), .o_reg_hit(o_reg_hit),
    .o_special_page(o_page), .o_tx_load_allow(o_load), .o_rx_enable(o_rx_en),
    .o_nine_bit_mode(o_nine), .o_rts_n(o_rts_n), .o_tx_line(o_tx_line));
  remote_uart_model u_remote (.i_clk(i_clk), .i_req(flow_req), .o_flow(i_flow));

  // 40 mhz clock
  initial
  begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  function automatic logic [16:0] lfsr_next(logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction

  task automatic chk(string name, logic [8:0] exp, logic [8:0] got);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic idle(int n);
    repeat (n) @(negedge i_clk);
  endtask

  // one-cycle write strobe, driven off the falling edge
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
  endtask

  // read strobe; the expected hit and data are noted for the watcher
  task automatic rd(logic [3:0] a, logic hit, logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    exp_q.push_back({hit, d});
    @(negedge i_clk);
    i_reg_rd = 1'b0;
  endtask

  // raise flow events for one cycle, keep the remote halt level, then read status
  task automatic ev(logic [4:0] r, logic [7:0] st);
    @(negedge i_clk);
    flow_req = r;
    idle(1);
    flow_req = r & 5'h04;
    idle(2);
    rd(uart_xfc_pkg::ADDR_FLOW_STATUS, 1'b1, st);
  endtask

  // the answer is registered at the strobe edge and hit stands one cycle: look at the next fall
  always @(posedge i_clk) rd_sh <= i_reg_rd;
  always @(negedge i_clk)
    if (rd_sh)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 9'h000, 9'h1ff);
      else
        chk("read hit,data", exp_q.pop_front(), {o_reg_hit, o_reg_rdata});
    end

  // watchdog so a stuck run still reaches the verdict
  initial
  begin
    repeat (5000) @(posedge i_clk);
    mismatches++;
    final_report();
  end

  initial
  begin
    {i_reset, i_soft_reset, i_reg_wr, i_reg_rd, i_reg_addr, i_reg_wdata} = '0;
    {flow_req, i_fifo, i_shift, i_rts_man, i_tx_bit, i_bit_start, i_tick, i_irda} = '0;
    i_line_control = 8'h00;
    rd_sh = 1'b0;
    lfsr = 17'h1678d;
    i_reset = 1'b1;
    idle(5);
    i_reset = 1'b0;
    i_line_control = uart_xfc_pkg::LCR_SPECIAL_VALUE;
    rd(uart_xfc_pkg::ADDR_UNLOCK_KEY, 1'b1, 8'h00);
    rd(uart_xfc_pkg::ADDR_EXTRA_FEAT, 1'b1, 8'h00);
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'hff);
    rd(uart_xfc_pkg::ADDR_EXTRA_FEAT, 1'b1, 8'hb7);
    idle(1);
    chk("rx enable", 9'h000, {8'h00, o_rx_en});
    chk("nine bit", 9'h001, {8'h00, o_nine});
    chk("load allow", 9'h000, {8'h00, o_load});
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'h00);
    idle(2);
    chk("rx enable", 9'h001, {8'h00, o_rx_en});
    // wrong key, then a key write outside the special window
    wr(uart_xfc_pkg::ADDR_UNLOCK_KEY, 8'h5b);
    wr(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 8'h04);
    rd(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 1'b0, 8'h00);
    rd(uart_xfc_pkg::ADDR_FLOW_STATUS, 1'b0, 8'h00);
    i_line_control = 8'h03;
    wr(uart_xfc_pkg::ADDR_UNLOCK_KEY, 8'h5a);
    rd(uart_xfc_pkg::ADDR_UNLOCK_KEY, 1'b0, 8'h00);
    i_line_control = uart_xfc_pkg::LCR_SPECIAL_VALUE;
    rd(uart_xfc_pkg::ADDR_UNLOCK_KEY, 1'b1, 8'h5b);
    wr(uart_xfc_pkg::ADDR_UNLOCK_KEY, uart_xfc_pkg::UNLOCK_KEY_VALUE);
    rd(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 1'b1, 8'h00);
    wr(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 8'h04);
    rd(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 1'b1, 8'h04);
    rd(uart_xfc_pkg::ADDR_EXTRA_FEAT, 1'b0, 8'h00);
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'hff);
    chk("special page", 9'h001, {8'h00, o_page});
    rd(uart_xfc_pkg::ADDR_FLOW_STATUS, 1'b1, 8'h00);
    ev(5'h10, 8'h10);
    ev(5'h04, 8'h21);
    ev(5'h06, 8'h23);
    ev(5'h0c, 8'h33);
    ev(5'h05, 8'h31);
    ev(5'h00, 8'h00);
    // closing the page shows the write refused above left the register untouched
    wr(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 8'h00);
    rd(uart_xfc_pkg::ADDR_EXTRA_FEAT, 1'b1, 8'h00);
    wr(uart_xfc_pkg::ADDR_SPECIAL_FUNC, 8'h04);
    // software reset from the gpio area clears key and page
    @(negedge i_clk);
    i_soft_reset = 1'b1;
    idle(1);
    i_soft_reset = 1'b0;
    rd(uart_xfc_pkg::ADDR_UNLOCK_KEY, 1'b1, 8'h00);
    rd(uart_xfc_pkg::ADDR_EXTRA_FEAT, 1'b1, 8'h00);
    chk("special page", 9'h000, {8'h00, o_page});
    // polarity set but auto off: pin follows the manual level, line follows the shifter
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'h20);
    i_shift = 1'b1;
    repeat (8)
    begin
      lfsr = lfsr_next(lfsr);
      i_rts_man = lfsr[0];
      i_tx_bit = lfsr[1];
      idle(1);
      chk("rts manual", {8'h00, lfsr[0]}, {8'h00, o_rts_n});
      chk("tx line", {8'h00, lfsr[1]}, {8'h00, o_tx_line});
    end
    // auto direction, both polarities, shifting through the last stop bit or idle
    for (int k = 0; k < 4; k++)
    begin
      wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, {2'h0, k[1], 5'h10});
      i_shift = k[0];
      i_rts_man = ~(k[0] ? k[1] : ~k[1]);
      idle(3);
      chk("rts auto", {8'h00, k[0] ? k[1] : ~k[1]}, {8'h00, o_rts_n});
    end
    // queued data keeps the driver on, unless the transmitter is disabled
    i_shift = 1'b0;
    i_fifo = 1'b1;
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'h10);
    idle(2);
    chk("rts fifo", 9'h000, {8'h00, o_rts_n});
    wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, 8'h14);
    idle(2);
    chk("rts tx disabled", 9'h001, {8'h00, o_rts_n});
    i_fifo = 1'b0;
    // infrared pulse width for a zero bit, 3/16 then 1/4 of the cell
    for (int q = 0; q < 2; q++)
    begin
      wr(uart_xfc_pkg::ADDR_EXTRA_FEAT, {q[0], 7'h00});
      {i_irda, i_tick, i_tx_bit, i_bit_start} = 4'b1101;
      cnt = 0;
      idle(1);
      i_bit_start = 1'b0;
      // the pulse starts at the bit-start edge, so count from that edge's output
      repeat (12)
      begin
        cnt += o_tx_line;
        idle(1);
      end
      chk("ir pulse", q ? 9'h004 : 9'h003, 9'(cnt));
      {i_irda, i_tick} = 2'b00;
      idle(20);
    end
    idle(3);
    chk("reads pending", 9'h000, 9'(exp_q.size()));
    final_report();
  end
endmodule
